// >>> logic/dbs_defines.svh
// Constants of the dual buck fault supervisor: register map, field positions, reset values and timing.
// Assumes a 25 MHz system clock. The analog comparators sit outside and report through flag pins.
`ifndef DBS_DEFINES_SVH
`define DBS_DEFINES_SVH

`define DBS_OFS_CTRL       8'h00
`define DBS_OFS_STATUS     8'h04
`define DBS_CTRL_SW_OFF    0
`define DBS_CTRL_RST       32'h0000_0000
`define DBS_ST_OVL0        0
`define DBS_ST_OVL1        1
`define DBS_ST_UVL         2
`define DBS_ST_PG0         3
`define DBS_ST_PG1         4
`define DBS_ST_OTEMP       5
`define DBS_ST_REF         6
`define DBS_ST_RUN0        7
`define DBS_ST_RUN1        8
`define DBS_RESP_OKAY      2'b00
`define DBS_RESP_SLVERR    2'b10

`define DBS_CLK_NS         40
`define DBS_TICK_NS        4000
`define DBS_TICK_CYC       ((`DBS_TICK_NS) / (`DBS_CLK_NS))
`define DBS_PG_TICKS       256
`define DBS_UV_TICKS       128

`endif

// >>> logic/dbs_pkg.sv
// Types of the dual buck fault supervisor.
// Assumes the AXI4-Lite master keeps the published channel rules.
package dbs_pkg;

   typedef enum logic [1:0] {
      DBS_CH_OFF  = 2'b00,
      DBS_CH_WAIT = 2'b01,
      DBS_CH_RUN  = 2'b11
   } dbs_ch_st_t;

   typedef struct packed {
      logic        awvalid;
      logic [7:0]  awaddr;
      logic        wvalid;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        bready;
      logic        arvalid;
      logic [7:0]  araddr;
      logic        rready;
   } dbs_axi_req_t;

   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } dbs_axi_rsp_t;

endpackage : dbs_pkg

// >>> logic/dbs_supervisor.sv
// Protection and sequencing supervisor for a two-channel step-down controller, with AXI4-Lite registers.
// Assumes all flag pins are asynchronous and i_rst_n is low while the driver supply is locked out.
`timescale 1ns/1ps
`include "dbs_defines.svh"

module dbs_supervisor (
   input  wire logic                  i_clk_sys,
   input  wire logic                  i_rst_n,
   input  wire logic [1:0]            i_enable_ch,
   input  wire logic                  i_enable_ldo_5v,
   input  wire logic                  i_enable_ldo_3v3,
   input  wire logic [1:0]            i_pwm_high_req,
   input  wire logic [1:0]            i_pwm_low_req,
   input  wire logic [1:0]            i_ov_flag,
   input  wire logic [1:0]            i_uv_flag_nominal,
   input  wire logic [1:0]            i_uv_flag_lowered,
   input  wire logic [1:0]            i_oc_flag_resistor,
   input  wire logic [1:0]            i_oc_flag_rdson,
   input  wire logic                  i_sense_select_resistor,
   input  wire logic [1:0]            i_fb_in_wide_window,
   input  wire logic [1:0]            i_fb_in_narrow_window,
   input  wire logic [1:0]            i_ss_above_nominal,
   input  wire logic [1:0]            i_ss_reached_output,
   input  wire logic                  i_rail_5v_low,
   input  wire logic                  i_output_ch1_above_switchover,
   input  wire logic                  i_over_temp,
   input  wire logic                  i_ref_shorted,
   input  wire dbs_pkg::dbs_axi_req_t i_axi,
   output dbs_pkg::dbs_axi_rsp_t      o_axi,
   output logic [1:0]                 o_high_side_gate,
   output logic [1:0]                 o_low_side_gate,
   output logic [1:0]                 o_discharge,
   output logic [1:0]                 o_power_ok,
   output logic                       o_rail_5v_ldo_on,
   output logic                       o_rail_3v3_ldo_on,
   output logic                       o_aux_reference_on
);
   import dbs_pkg::*;

   localparam int NPIN = 27;
   localparam logic [6:0] TICK_LAST = 7'(`DBS_TICK_CYC - 1);
   localparam logic [8:0] PG_DONE   = 9'(`DBS_PG_TICKS);
   localparam logic [7:0] UV_DONE   = 8'(`DBS_UV_TICKS);

   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   logic [NPIN-1:0] pin_raw;
   logic [NPIN-1:0] s1_r;
   logic [NPIN-1:0] s2_r;
   logic [NPIN-1:0] s3_r;
   logic [NPIN-1:0] f_r;

   assign pin_raw = {i_enable_ch, i_enable_ldo_5v, i_enable_ldo_3v3, i_ov_flag, i_uv_flag_nominal,
                     i_uv_flag_lowered, i_oc_flag_resistor, i_oc_flag_rdson, i_sense_select_resistor,
                     i_fb_in_wide_window, i_fb_in_narrow_window, i_ss_above_nominal, i_ss_reached_output,
                     i_rail_5v_low, i_output_ch1_above_switchover, i_over_temp, i_ref_shorted};

   // A bit is taken once the second and third stages agree.
   always_ff @(posedge i_clk_sys or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
         f_r  <= '0;
      end
      else
      begin
         s1_r <= pin_raw;
         s2_r <= s1_r;
         s3_r <= s2_r;
         for (int k = 0; k < NPIN; k++)
         begin
            if (s2_r[k] == s3_r[k])
            begin
               f_r[k] <= s3_r[k];
            end
         end
      end
   end

   logic [1:0] en;
   logic       en5;
   logic       en3;
   logic [1:0] ov;
   logic [1:0] uv_nom;
   logic [1:0] uv_low;
   logic [1:0] oc_res;
   logic [1:0] oc_rds;
   logic       sel_res;
   logic [1:0] wide;
   logic [1:0] narrow;
   logic [1:0] ss_nom;
   logic [1:0] ss_out;
   logic       rail_low;
   logic       ch1_high;
   logic       otemp;
   logic       ref_short;

   assign {en, en5, en3, ov, uv_nom, uv_low, oc_res, oc_rds, sel_res, wide, narrow, ss_nom, ss_out,
           rail_low, ch1_high, otemp, ref_short} = f_r;

   // ---------------------------------------------------------------
   // Internal 4 us tick
   // ---------------------------------------------------------------
   logic [6:0] div_r;
   logic       tick;

   always_ff @(posedge i_clk_sys or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         div_r <= '0;
      end
      else
      begin
         div_r <= (div_r == TICK_LAST) ? 7'h00 : div_r + 7'h01;
      end
   end
   assign tick = (div_r == TICK_LAST);

   // ---------------------------------------------------------------
   // Registers and fault latches
   // ---------------------------------------------------------------
   logic [31:0] ctrl_r;
   logic [1:0]  en_d_r;
   logic [1:0]  en_rise;
   logic [1:0]  ov_lat_r;
   logic        uv_lat_r;
   logic [1:0]  uv_arm_r;
   logic [7:0]  uv_cnt_r [2];
   logic [1:0]  uv_sel;
   logic        ov_any;
   logic        sw_off;

   assign en_rise = en & ~en_d_r;
   assign ov_any  = |ov_lat_r;
   assign sw_off  = ctrl_r[`DBS_CTRL_SW_OFF];
   assign uv_sel  = rail_low ? uv_low : uv_nom;

   always_ff @(posedge i_clk_sys or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         en_d_r   <= '0;
         ov_lat_r <= '0;
         uv_lat_r <= 1'b0;
         uv_arm_r <= '0;
         uv_cnt_r <= '{default: 8'h00};
      end
      else
      begin
         en_d_r <= en;
         for (int c = 0; c < 2; c++)
         begin
            if (ov[c])
            begin
               ov_lat_r[c] <= 1'b1;
            end
            else if (en_rise[c] || otemp)
            begin
               ov_lat_r[c] <= 1'b0;
            end
            if (!en[c])
            begin
               uv_arm_r[c] <= 1'b0;
            end
            else if (ss_nom[c])
            begin
               uv_arm_r[c] <= 1'b1;
            end
            if (!(uv_sel[c] && uv_arm_r[c]))
            begin
               uv_cnt_r[c] <= 8'h00;
            end
            else if (tick && uv_cnt_r[c] != UV_DONE)
            begin
               uv_cnt_r[c] <= uv_cnt_r[c] + 8'h01;
            end
         end
         if (uv_cnt_r[0] == UV_DONE || uv_cnt_r[1] == UV_DONE)
         begin
            uv_lat_r <= 1'b1;
         end
         else if ((|en_rise) || otemp)
         begin
            uv_lat_r <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // Channel sequencing and gate commands
   // ---------------------------------------------------------------
   dbs_ch_st_t st_r [2];
   logic [1:0] run_ok;
   logic [1:0] oc_hold_r;
   logic [1:0] hi_r;
   logic [1:0] lo_r;
   logic [1:0] dis_r;
   logic [1:0] oc;

   assign oc = sel_res ? oc_res : oc_rds;

   // Supply lockout acts through the reset, so every latch and counter restarts on recovery.
   always_comb
   begin
      for (int c = 0; c < 2; c++)
      begin
         run_ok[c] = en[c] && !ov_any && !uv_lat_r && !otemp && !ref_short && !sw_off;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         st_r      <= '{default: DBS_CH_OFF};
         oc_hold_r <= '0;
         hi_r      <= '0;
         lo_r      <= '0;
         dis_r     <= 2'b11;
      end
      else
      begin
         for (int c = 0; c < 2; c++)
         begin
            unique case (st_r[c])
               DBS_CH_OFF:  if (run_ok[c]) st_r[c] <= DBS_CH_WAIT;
               DBS_CH_WAIT: if (!run_ok[c]) st_r[c] <= DBS_CH_OFF;
                            else if (ss_out[c]) st_r[c] <= DBS_CH_RUN;
               DBS_CH_RUN:  if (!run_ok[c]) st_r[c] <= DBS_CH_OFF;
               default:     st_r[c] <= DBS_CH_OFF;
            endcase
            dis_r[c] <= !run_ok[c];
            if (lo_r[c] && oc[c])
            begin
               oc_hold_r[c] <= 1'b1;
            end
            else if (!oc[c])
            begin
               oc_hold_r[c] <= 1'b0;
            end
            if (ov_lat_r[c])
            begin
               hi_r[c] <= 1'b0;
               lo_r[c] <= 1'b1;
            end
            else if (!run_ok[c] || st_r[c] != DBS_CH_RUN)
            begin
               hi_r[c] <= 1'b0;
               lo_r[c] <= 1'b0;
            end
            else
            begin
               hi_r[c] <= i_pwm_high_req[c] && (hi_r[c] || !oc_hold_r[c]);
               lo_r[c] <= i_pwm_low_req[c] && !i_pwm_high_req[c];
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // Power-good qualification
   // ---------------------------------------------------------------
   logic [8:0] pg_cnt_r [2];
   logic [1:0] pg_r;
   logic       pg_force;

   assign pg_force = ov_any || uv_lat_r || otemp || ref_short;

   always_ff @(posedge i_clk_sys or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         pg_cnt_r <= '{default: 9'h000};
         pg_r     <= '0;
      end
      else
      begin
         for (int c = 0; c < 2; c++)
         begin
            if (pg_force || st_r[c] != DBS_CH_RUN || !narrow[c])
            begin
               pg_cnt_r[c] <= 9'h000;
            end
            else if (tick && pg_cnt_r[c] != PG_DONE)
            begin
               pg_cnt_r[c] <= pg_cnt_r[c] + 9'h001;
            end
            if (pg_force || !run_ok[c] || !wide[c])
            begin
               pg_r[c] <= 1'b0;
            end
            else if (pg_cnt_r[c] == PG_DONE)
            begin
               pg_r[c] <= 1'b1;
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // Standby regulators and auxiliary reference
   // ---------------------------------------------------------------
   logic ldo5_r;
   logic ldo3_r;
   logic ref_r;

   always_ff @(posedge i_clk_sys or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         ldo5_r <= 1'b0;
         ldo3_r <= 1'b0;
         ref_r  <= 1'b0;
      end
      else
      begin
         // The regulator enable alone never stops the switchers; the system drops it together with channel 0 only.
         ldo5_r <= en5 && !otemp && !ch1_high;
         ldo3_r <= en3 && !otemp;
         if (otemp)
         begin
            ref_r <= 1'b0;
         end
         else if (en5 && en3)
         begin
            ref_r <= 1'b1;
         end
         else if (st_r[0] == DBS_CH_OFF && st_r[1] == DBS_CH_OFF)
         begin
            ref_r <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // AXI4-Lite slave
   // ---------------------------------------------------------------
   logic        awrdy_r;
   logic        wrdy_r;
   logic        bvld_r;
   logic [1:0]  bresp_r;
   logic        arrdy_r;
   logic        rvld_r;
   logic [31:0] rdata_r;
   logic [1:0]  rresp_r;
   logic [7:0]  waddr_r;
   logic [31:0] wdata_r;
   logic [3:0]  wstrb_r;
   logic [31:0] status;

   always_comb
   begin
      status                 = 32'h0000_0000;
      status[`DBS_ST_OVL0]   = ov_lat_r[0];
      status[`DBS_ST_OVL1]   = ov_lat_r[1];
      status[`DBS_ST_UVL]    = uv_lat_r;
      status[`DBS_ST_PG0]    = pg_r[0];
      status[`DBS_ST_PG1]    = pg_r[1];
      status[`DBS_ST_OTEMP]  = otemp;
      status[`DBS_ST_REF]    = ref_r;
      status[`DBS_ST_RUN0]   = (st_r[0] == DBS_CH_RUN);
      status[`DBS_ST_RUN1]   = (st_r[1] == DBS_CH_RUN);
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         awrdy_r <= 1'b1;
         wrdy_r  <= 1'b1;
         bvld_r  <= 1'b0;
         bresp_r <= `DBS_RESP_OKAY;
         waddr_r <= '0;
         wdata_r <= '0;
         wstrb_r <= '0;
         ctrl_r  <= `DBS_CTRL_RST;
      end
      else
      begin
         if (i_axi.awvalid && awrdy_r)
         begin
            waddr_r <= i_axi.awaddr;
            awrdy_r <= 1'b0;
         end
         if (i_axi.wvalid && wrdy_r)
         begin
            wdata_r <= i_axi.wdata;
            wstrb_r <= i_axi.wstrb;
            wrdy_r  <= 1'b0;
         end
         if (!awrdy_r && !wrdy_r && !bvld_r)
         begin
            bvld_r  <= 1'b1;
            bresp_r <= `DBS_RESP_OKAY;
            if (waddr_r == `DBS_OFS_CTRL)
            begin
               for (int b = 0; b < 4; b++)
               begin
                  if (wstrb_r[b])
                  begin
                     ctrl_r[8*b +: 8] <= wdata_r[8*b +: 8];
                  end
               end
            end
            else if (waddr_r != `DBS_OFS_STATUS)
            begin
               bresp_r <= `DBS_RESP_SLVERR;
            end
         end
         if (bvld_r && i_axi.bready)
         begin
            bvld_r  <= 1'b0;
            awrdy_r <= 1'b1;
            wrdy_r  <= 1'b1;
         end
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         arrdy_r <= 1'b1;
         rvld_r  <= 1'b0;
         rdata_r <= '0;
         rresp_r <= `DBS_RESP_OKAY;
      end
      else if (i_axi.arvalid && arrdy_r)
      begin
         arrdy_r <= 1'b0;
         rvld_r  <= 1'b1;
         rresp_r <= `DBS_RESP_OKAY;
         unique case (i_axi.araddr)
            `DBS_OFS_CTRL:   rdata_r <= ctrl_r;
            `DBS_OFS_STATUS: rdata_r <= status;
            default:
            begin
               rdata_r <= 32'h0000_0000;
               rresp_r <= `DBS_RESP_SLVERR;
            end
         endcase
      end
      else if (rvld_r && i_axi.rready)
      begin
         rvld_r  <= 1'b0;
         arrdy_r <= 1'b1;
      end
   end

   assign o_axi = '{awready: awrdy_r, wready: wrdy_r, bvalid: bvld_r, bresp: bresp_r,
                    arready: arrdy_r, rvalid: rvld_r, rdata: rdata_r, rresp: rresp_r};
   assign o_high_side_gate   = hi_r;
   assign o_low_side_gate    = lo_r;
   assign o_discharge        = dis_r;
   assign o_power_ok         = pg_r;
   assign o_rail_5v_ldo_on   = ldo5_r;
   assign o_rail_3v3_ldo_on  = ldo3_r;
   assign o_aux_reference_on = ref_r;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_n);

   off_discharge_a: assert property (!run_ok[0] |=> dis_r[0] && !hi_r[0])
      else $error("channel 0 off without discharge");
   stop_lowside_a: assert property ((dis_r[1] && !$past(ov_lat_r[1])) |-> !lo_r[1])
      else $error("low side on during soft stop");
   resume_ref_a: assert property ($rose(st_r[0] == DBS_CH_RUN) |-> $past(ss_out[0]))
      else $error("resumed before reference matched");
   pg_qualify_a: assert property ($rose(pg_r[0]) |-> $past(pg_cnt_r[0]) == PG_DONE)
      else $error("power good released before qualification");
   pg_drop_a: assert property (!wide[1] |=> !pg_r[1])
      else $error("power good not dropped");
   pg_force_a: assert property (pg_force |=> pg_r == 2'b00)
      else $error("power good high during fault");
   oc_inhibit_a: assert property ((oc_hold_r[0] && !hi_r[0]) |=> !hi_r[0])
      else $error("high side started during overcurrent");
   ov_latch_a: assert property ($rose(ov[0]) |=> ##1 (hi_r == 2'b00 && lo_r[0] && !lo_r[1]))
      else $error("overvoltage latch gate state wrong");
   uv_latch_a: assert property ($rose(uv_lat_r) |=> (hi_r == 2'b00 && lo_r == 2'b00))
      else $error("undervoltage latch left gates on");
   uv_mask_a: assert property (!$past(uv_arm_r[1]) |-> uv_cnt_r[1] == 8'h00)
      else $error("undervoltage counted while masked");
   otemp_off_a: assert property (otemp |=> !ldo5_r && !ldo3_r && hi_r == 2'b00)
      else $error("over temperature left outputs on");
   ref_on_a: assert property ($rose(ref_r) |-> $past(en5 && en3))
      else $error("reference enabled without both regulators");
   ldo_switch_a: assert property (ch1_high |=> !ldo5_r)
      else $error("5 V regulator on above switchover");

   pg_up_c: cover property ($rose(pg_r[0]));
   uv_trip_c: cover property ($rose(uv_lat_r));
   ov_trip_c: cover property ($rose(ov_lat_r[0]));
   oc_hold_c: cover property (oc_hold_r[1] && i_pwm_high_req[1]);

endmodule : dbs_supervisor

// >>> verif/dbs_far_side.sv
// Far-side model: system enable logic and the external power stage.
// Assumes the supervisor's gate and discharge commands and the bench's requests.
`timescale 1ns/1ps
module dbs_far_side (
   input  wire logic       i_clk_sys,
   input  wire logic       i_rst_n,
   input  wire logic [1:0] i_high_side_gate,
   input  wire logic [1:0] i_discharge,
   input  wire logic [1:0] i_en_req,
   input  wire logic       i_ldo_req,
   input  wire logic [1:0] i_fb_bad,
   input  wire logic [1:0] i_ss_ok,
   output logic [1:0]      o_enable_ch,
   output logic            o_enable_ldo_5v,
   output logic            o_enable_ldo_3v3,
   output logic [1:0]      o_fb_win,
   output logic [1:0]      o_ss_reached
);
   logic [1:0] out_up_r;
   // The 5 V switcher is never left enabled without its regulator.
   assign o_enable_ch      = {i_en_req[1], i_en_req[0] & i_ldo_req};
   assign o_enable_ldo_5v  = i_ldo_req;
   assign o_enable_ldo_3v3 = 1'b1;
   // An output charges once switched and loses charge only through discharge.
   always_ff @(posedge i_clk_sys or negedge i_rst_n)
      if (!i_rst_n)
         out_up_r <= 2'b00;
      else
         out_up_r <= (out_up_r | i_high_side_gate) & ~i_discharge;
   assign o_fb_win     = out_up_r & ~i_fb_bad;
   assign o_ss_reached = o_enable_ch & i_ss_ok;
endmodule : dbs_far_side

// >>> verif/tb.sv
// Self-checking bench for the dual buck fault supervisor.
// Assumes dbs_far_side as the far side and a 25 MHz clock.
`timescale 1ns/1ps
module tb;
   import dbs_pkg::*;
   logic         clk, rst_n, ldo_req, sel, sw, ot, rsh, rl, l5, l3, aux, l5e, l3e;
   logic [1:0]   hreq, lreq, ov, uvn, uvl, ocr, ocd, ssn, en_req, fb_bad, ss_ok;
   logic [1:0]   hs, ls, dis, pok, en, fw, ssr, resp;
   logic [31:0]  rd;
   dbs_axi_req_t ax;
   dbs_axi_rsp_t rs;
   int           n_mismatch = 0;
   int           num_checks = 0;
   dbs_supervisor dut (.i_clk_sys(clk), .i_rst_n(rst_n), .i_enable_ch(en), .i_enable_ldo_5v(l5e),
      .i_enable_ldo_3v3(l3e), .i_pwm_high_req(hreq), .i_pwm_low_req(lreq), .i_ov_flag(ov),
      .i_uv_flag_nominal(uvn), .i_uv_flag_lowered(uvl), .i_oc_flag_resistor(ocr), .i_oc_flag_rdson(ocd),
      .i_sense_select_resistor(sel), .i_fb_in_wide_window(fw), .i_fb_in_narrow_window(fw),
      .i_ss_above_nominal(ssn), .i_ss_reached_output(ssr), .i_rail_5v_low(rl),
      .i_output_ch1_above_switchover(sw), .i_over_temp(ot), .i_ref_shorted(rsh), .i_axi(ax), .o_axi(rs),
      .o_high_side_gate(hs), .o_low_side_gate(ls), .o_discharge(dis), .o_power_ok(pok),
      .o_rail_5v_ldo_on(l5), .o_rail_3v3_ldo_on(l3), .o_aux_reference_on(aux));
   dbs_far_side far (.i_clk_sys(clk), .i_rst_n(rst_n), .i_high_side_gate(hs), .i_discharge(dis),
      .i_en_req(en_req), .i_ldo_req(ldo_req), .i_fb_bad(fb_bad), .i_ss_ok(ss_ok), .o_enable_ch(en),
      .o_enable_ldo_5v(l5e), .o_enable_ldo_3v3(l3e), .o_fb_win(fw), .o_ss_reached(ssr));
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // One edge passes first, so a back-to-back call never drives a signal twice in one time step.
   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      bit done;
      done = 1'b0;
      @(posedge clk);
      ax.awvalid <= 1'b1;
      ax.awaddr  <= a;
      ax.wvalid  <= 1'b1;
      ax.wdata   <= d;
      ax.bready  <= 1'b1;
      resp = 2'bxx;
      while (!done)
      begin
         @(posedge clk);
         if (rs.awready && ax.awvalid)
            ax.awvalid <= 1'b0;
         if (rs.wready && ax.wvalid)
            ax.wvalid <= 1'b0;
         if (rs.bvalid)
         begin
            resp = rs.bresp;
            ax.bready <= 1'b0;
            done = 1'b1;
         end
      end
   endtask : axw
   task automatic axr(input logic [7:0] a);
      bit done;
      done = 1'b0;
      @(posedge clk);
      ax.arvalid <= 1'b1;
      ax.araddr  <= a;
      ax.rready  <= 1'b1;
      resp = 2'bxx;
      while (!done)
      begin
         @(posedge clk);
         if (rs.arready && ax.arvalid)
            ax.arvalid <= 1'b0;
         if (rs.rvalid)
         begin
            resp = rs.rresp;
            rd = rs.rdata;
            ax.rready <= 1'b0;
            done = 1'b1;
         end
      end
   endtask : axr
   task automatic t_start();
      en_req <= 2'b11;
      cyc(12);
      chk("dis", 32'h0, dis);
      chk("hs", 32'h0, hs);
      chk("aux", 32'h1, aux);
      ss_ok <= 2'b11;
      cyc(25412);
      chk("pok", 32'h0, pok);
      cyc(500);
      chk("pok", 32'h3, pok);
      fb_bad <= 2'b01;
      cyc(8);
      chk("pok", 32'h2, pok);
      fb_bad <= 2'b00;
      cyc(200);
      chk("pok", 32'h2, pok);
   endtask : t_start
   task automatic t_oc();
      for (int s = 0; s < 2; s++)
      begin
         sel  <= s[0];
         hreq <= 2'b00;
         lreq <= 2'b11;
         ocr  <= {~s[0], s[0]};
         ocd  <= {s[0], ~s[0]};
         cyc(8);
         lreq <= 2'b00;
         hreq <= 2'b11;
         cyc(4);
         chk("hs", 32'h2, hs);
         ocr <= 2'b00;
         ocd <= 2'b00;
         cyc(8);
         chk("hs", 32'h3, hs);
      end
   endtask : t_oc
   task automatic t_ov();
      ov <= 2'b01;
      cyc(8);
      chk("gates", 32'h1, {hs, ls});
      chk("pok", 32'h0, pok);
      chk("dis", 32'h3, dis);
      ov <= 2'b00;
      cyc(8);
      axr(8'h04);
      chk("ovl", 32'h1, rd[1:0]);
      chk("hs", 32'h0, hs);
      en_req <= 2'b10;
      cyc(8);
      chk("dis", 32'h1, dis[0]);
      chk("ls", 32'h1, ls);
      en_req <= 2'b11;
      ss_ok  <= 2'b10;
      cyc(8);
      chk("dis", 32'h0, dis[0]);
      chk("hs", 32'h0, hs[0]);
      ss_ok <= 2'b11;
      cyc(12);
      axr(8'h04);
      chk("ovl", 32'h0, rd[1:0]);
      chk("hs", 32'h3, hs);
   endtask : t_ov
   task automatic t_regs();
      axw(8'h00, 32'h1);
      cyc(4);
      chk("hs", 32'h0, hs);
      axr(8'h00);
      chk("ctrl", 32'h1, rd);
      axw(8'h00, 32'h0);
      axw(8'h08, 32'h1);
      chk("bresp", 32'h2, resp);
      axr(8'h0c);
      chk("rresp", 32'h2, resp);
      cyc(12);
      chk("hs", 32'h3, hs);
   endtask : t_regs
   task automatic t_faults();
      for (int f = 0; f < 2; f++)
      begin
         ot  <= (f == 0);
         rsh <= (f == 1);
         cyc(8);
         chk("gates", 32'h0, {hs, ls});
         chk("pok", 32'h0, pok);
         chk("ldo", f ? 32'h3 : 32'h0, {l5, l3});
         ot  <= 1'b0;
         rsh <= 1'b0;
         cyc(12);
         chk("hs", 32'h3, hs);
      end
      sw <= 1'b1;
      cyc(8);
      chk("l5", 32'h0, l5);
      sw    <= 1'b0;
      rst_n <= 1'b0;
      cyc(4);
      chk("lockout", 32'h30, {dis, hs, ls});
      rst_n <= 1'b1;
      cyc(16);
      chk("hs", 32'h3, hs);
   endtask : t_faults
   task automatic t_uv();
      uvn <= 2'b10;
      cyc(13000);
      chk("hs", 32'h3, hs);
      ssn <= 2'b11;
      rl  <= 1'b1;
      cyc(13000);
      chk("hs", 32'h3, hs);
      uvl <= 2'b10;
      cyc(12600);
      chk("hs", 32'h3, hs);
      cyc(600);
      chk("gates", 32'h0, {hs, ls});
      axr(8'h04);
      chk("uvl", 32'h1, rd[2]);
   endtask : t_uv
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : wrap_up
   initial
   begin
      cyc(80000);
      n_mismatch++;
      wrap_up();
   end
   initial
   begin
      rst_n   = 1'b0;
      ldo_req = 1'b1;
      hreq    = 2'b11;
      {lreq, ov, uvn, uvl, ocr, ocd, ssn, en_req, fb_bad, ss_ok} = '0;
      {sel, sw, ot, rsh, rl} = '0;
      ax       = '0;
      ax.wstrb = 4'hf;
      cyc(8);
      chk("reset", 32'h30, {dis, pok, hs});
      cyc(8);
      rst_n <= 1'b1;
      cyc(2);
      t_start();
      t_oc();
      t_ov();
      t_regs();
      t_faults();
      t_uv();
      wrap_up();
   end
endmodule : tb
